// >>> src/aim_pkg.sv
package aim_pkg;

    // Bus geometry
    localparam int unsigned AIM_ADR_W     = 8;
    localparam int unsigned AIM_DAT_W     = 32;
    localparam int unsigned AIM_SEL_W     = 4;

    // Converter geometry
    localparam int unsigned AIM_NUM_CH    = 8;
    localparam int unsigned AIM_CH_IDX_W  = 3;
    localparam int unsigned AIM_RES_W     = 10;
    localparam int unsigned AIM_SRC_W     = 20;
    localparam int unsigned AIM_EXT_W     = 12;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] AIM_OFS_INT_DISABLE = 8'h28;
    localparam logic [7:0] AIM_OFS_INT_MASK    = 8'h2C;
    localparam logic [7:0] AIM_OFS_EVT_STATUS  = 8'h30;
    localparam logic [7:0] AIM_OFS_RESULT_BASE = 8'h50;
    localparam logic [7:0] AIM_OFS_RESULT_LAST = 8'h6C;

    ////////////////////////////////////////////////////////////////////////////
    // Source field positions, shared by disable, mask and status
    localparam int unsigned AIM_POS_DONE      = 0;
    localparam int unsigned AIM_POS_OVERRUN   = 8;
    localparam int unsigned AIM_POS_READY     = 16;
    localparam int unsigned AIM_POS_GOVERRUN  = 17;
    localparam int unsigned AIM_POS_RX_END    = 18;
    localparam int unsigned AIM_POS_RX_FULL   = 19;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [19:0] AIM_RST_MASK      = 20'h00000;
    localparam logic [19:0] AIM_RST_STATUS    = 20'h00000;
    localparam logic [9:0]  AIM_RST_RESULT    = 10'h000;
    localparam logic [31:0] AIM_RD_UNMAPPED   = 32'h00000000;

    // Bus response latency in clock cycles from request to acknowledge
    localparam int unsigned AIM_ACK_CYCLES    = 1;

endpackage

// >>> src/aim_mask_reg.sv
`timescale 1ns/100ps
module aim_mask_reg
    import aim_pkg::*;
#(
    parameter int unsigned W = AIM_SRC_W
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         set_stb,
    input  wire logic [W-1:0] set_bits,
    input  wire logic         clr_stb,
    input  wire logic [W-1:0] clr_bits,
    output logic      [W-1:0] mask
);

    logic [W-1:0] mask_reg;
    logic [W-1:0] mask_next;
    logic [W-1:0] set_term;
    logic [W-1:0] clr_term;

    // Zero bits touch nothing; enable wins when both hit one bit
    assign set_term  = set_stb ? set_bits : '0;                  // [RULE9]
    assign clr_term  = clr_stb ? clr_bits : '0;                  // [RULE1]
    assign mask_next = (mask_reg & ~clr_term) | set_term;

    // Cleared at reset so nothing can interrupt before software asks
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            mask_reg <= AIM_RST_MASK[W-1:0];                     // [RULE12]
        else
            mask_reg <= mask_next;
    end

    assign mask = mask_reg;

endmodule

// >>> src/aim_result_bank.sv
`timescale 1ns/100ps
module aim_result_bank
    import aim_pkg::*;
#(
    parameter int unsigned N  = AIM_NUM_CH,
    parameter int unsigned IW = AIM_CH_IDX_W,
    parameter int unsigned W  = AIM_RES_W
)
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                eoc_stb,
    input  wire logic [IW-1:0]       eoc_chan,
    input  wire logic [W-1:0]        eoc_data,
    input  wire logic [N-1:0]        ch_enable,
    input  wire logic [N-1:0]        rd_clr,
    output logic      [N-1:0][W-1:0] result,
    output logic      [N-1:0]        done
);

    logic [N-1:0][W-1:0] result_reg;
    logic [N-1:0]        done_reg;
    logic [N-1:0]        load;
    logic [N-1:0]        done_next;

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_ch
            // Load only when this channel finishes and is enabled
            assign load[g] = eoc_stb && (eoc_chan == IW'(g)) && ch_enable[g];  // [RULE8]

            // Completion wins over the read clear; disable forces zero
            assign done_next[g] = ((done_reg[g] & ~rd_clr[g]) | load[g])
                                  & ch_enable[g];                             // [RULE10]

            // Result holds until the next completed conversion
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    result_reg[g] <= AIM_RST_RESULT[W-1:0];
                else if (load[g])
                    result_reg[g] <= eoc_data;                                // [RULE7]
            end
        end
    endgenerate

    // Done flags of all channels
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            done_reg <= '0;
        else
            done_reg <= done_next;
    end

    assign result = result_reg;
    assign done   = done_reg;

endmodule

// >>> src/aim_top.sv
// What this block does
// RULE1 - Disable write: each one bit clears its mask bit, zeros change nothing.
// RULE2 - Disable register is write-only: done 7:0, overrun 15:8, globals 16 to 19.
// RULE3 - Mask read shows one for every enabled interrupt source.
// RULE4 - Mask read shows zero for every disabled interrupt source.
// RULE5 - Mask register is read-only with the same layout as disable.
// RULE6 - Channel result registers are read-only, result in bits 9:0, rest zero.
// RULE7 - Result captured at conversion end, held until next conversion on that channel.
// RULE8 - Result updated only while the channel is enabled, else kept.
// RULE9 - Enable strobe: each one bit sets its mask bit, zeros change nothing.
// RULE10 - Done flag is one only for an enabled channel with finished conversion.
// RULE11 - Interrupt high while any flagged source is also unmasked.
// RULE12 - After reset every mask bit is cleared.
`timescale 1ns/100ps
module aim_top
    import aim_pkg::*;
(
    input  wire logic                    CLK_SYS,
    input  wire logic                    RST,
    // Wishbone classic slave
    input  wire logic                    WB_CYC_I,
    input  wire logic                    WB_STB_I,
    input  wire logic                    WB_WE_I,
    input  wire logic [AIM_ADR_W-1:0]    WB_ADR_I,
    input  wire logic [AIM_SEL_W-1:0]    WB_SEL_I,
    input  wire logic [AIM_DAT_W-1:0]    WB_DAT_I,
    output logic      [AIM_DAT_W-1:0]    WB_DAT_O,
    output logic                         WB_ACK_O,
    // Converter side, same clock
    input  wire logic                    IER_WR_STB,
    input  wire logic [AIM_SRC_W-1:0]    IER_WR_DATA,
    input  wire logic [AIM_EXT_W-1:0]    STATUS_FLAGS,
    input  wire logic [AIM_NUM_CH-1:0]   CH_ENABLE,
    input  wire logic                    EOC_STB,
    input  wire logic [AIM_CH_IDX_W-1:0] EOC_CHAN,
    input  wire logic [AIM_RES_W-1:0]    EOC_DATA,
    output logic      [AIM_NUM_CH-1:0]   CONV_DONE,
    output logic      [AIM_SRC_W-1:0]    INT_MASK,
    output logic                         ADC_IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte-lane enables widened to a bit mask
    function automatic logic [AIM_DAT_W-1:0] lane_mask(input logic [AIM_SEL_W-1:0] sel);
        logic [AIM_DAT_W-1:0] m;
        m = '0;
        for (int i = 0; i < AIM_SEL_W; i++)
            m[i*8 +: 8] = {8{sel[i]}};
        return m;
    endfunction

    // Word address match, low two bits ignored
    function automatic logic word_hit(input logic [AIM_ADR_W-1:0] a,
                                      input logic [AIM_ADR_W-1:0] ofs);
        return a[AIM_ADR_W-1:2] == ofs[AIM_ADR_W-1:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic                              ack_reg;
    logic [AIM_DAT_W-1:0]              dat_reg;
    logic [AIM_DAT_W-1:0]              dat_next;
    logic                              access;
    logic                              wr_access;
    logic                              rd_access;
    logic [AIM_DAT_W-1:0]              wr_bits;
    logic                              hit_disable;
    logic                              hit_mask;
    logic                              hit_status;
    logic                              hit_result;
    logic [AIM_CH_IDX_W-1:0]           result_idx;
    logic [AIM_ADR_W-1:0]              result_off;
    logic [AIM_NUM_CH-1:0]             result_rd;
    logic                              disable_wr;
    logic [AIM_SRC_W-1:0]              mask;
    logic [AIM_NUM_CH-1:0][AIM_RES_W-1:0] result;
    logic [AIM_NUM_CH-1:0]             done;
    logic [AIM_SRC_W-1:0]              flags;
    logic [AIM_SRC_W-1:0]              status_reg;
    logic [AIM_SRC_W-1:0]              status_next;
    logic                              status_rd;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // One access per request; ack_reg blocks a second take of the same one
    assign access     = WB_CYC_I && WB_STB_I && !ack_reg;
    assign wr_access  = access && WB_WE_I;
    assign rd_access  = access && !WB_WE_I;
    assign wr_bits    = WB_DAT_I & lane_mask(WB_SEL_I);

    assign hit_disable = word_hit(WB_ADR_I, AIM_OFS_INT_DISABLE);
    assign hit_mask    = word_hit(WB_ADR_I, AIM_OFS_INT_MASK);
    assign hit_status  = word_hit(WB_ADR_I, AIM_OFS_EVT_STATUS);
    assign hit_result  = (WB_ADR_I >= AIM_OFS_RESULT_BASE)
                         && (WB_ADR_I <= (AIM_OFS_RESULT_LAST | 8'h03));
    assign result_off  = WB_ADR_I - AIM_OFS_RESULT_BASE;
    assign result_idx  = result_off[AIM_CH_IDX_W+1:2];

    // Disable is write-only; a write elsewhere is acknowledged and dropped
    assign disable_wr  = wr_access && hit_disable;                       // [RULE2]

    // Reading a channel result also retires its done flag
    genvar c;
    generate
        for (c = 0; c < AIM_NUM_CH; c++)
        begin : g_rd
            assign result_rd[c] = rd_access && hit_result
                                  && (result_idx == AIM_CH_IDX_W'(c));
        end
    endgenerate

    assign status_rd = rd_access && hit_status;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt mask: set by the enable strobe, cleared by disable writes

    aim_mask_reg #(
        .W        (AIM_SRC_W)
    ) u_mask (
        .clk      (CLK_SYS),
        .rst      (RST),
        .set_stb  (IER_WR_STB),
        .set_bits (IER_WR_DATA),
        .clr_stb  (disable_wr),
        .clr_bits (wr_bits[AIM_SRC_W-1:0]),                              // [RULE1]
        .mask     (mask)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Channel results and done flags

    aim_result_bank #(
        .N         (AIM_NUM_CH),
        .IW        (AIM_CH_IDX_W),
        .W         (AIM_RES_W)
    ) u_bank (
        .clk       (CLK_SYS),
        .rst       (RST),
        .eoc_stb   (EOC_STB),
        .eoc_chan  (EOC_CHAN),
        .eoc_data  (EOC_DATA),
        .ch_enable (CH_ENABLE),
        .rd_clr    (result_rd),
        .result    (result),
        .done      (done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sticky event status, cleared by a read

    // Done flags sit in 7:0, converter flags above them
    assign flags = {STATUS_FLAGS, done};

    // A flag present in the read cycle wins, so no event is lost
    assign status_next = (status_rd ? '0 : status_reg) | flags;

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            status_reg <= AIM_RST_STATUS;
        else
            status_reg <= status_next;
    end

    // Level output; a still-high flag re-arms the bit after a read
    assign ADC_IRQ = |(status_reg & mask);                              // [RULE11]

    ////////////////////////////////////////////////////////////////////////////
    // Read data select

    // Unused upper bits read as zero in every register
    always_comb
    begin
        dat_next = AIM_RD_UNMAPPED;
        if (hit_mask)
            dat_next = {{(AIM_DAT_W-AIM_SRC_W){1'b0}}, mask};           // [RULE3] [RULE4] [RULE5]
        else if (hit_status)
            dat_next = {{(AIM_DAT_W-AIM_SRC_W){1'b0}}, status_reg};
        else if (hit_result)
            dat_next = {{(AIM_DAT_W-AIM_RES_W){1'b0}}, result[result_idx]}; // [RULE6]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge and data registers, one cycle after the request

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            ack_reg <= 1'b0;
            dat_reg <= AIM_RD_UNMAPPED;
        end
        else
        begin
            ack_reg <= access;
            if (rd_access)
                dat_reg <= dat_next;
        end
    end

    assign WB_ACK_O  = ack_reg;
    assign WB_DAT_O  = dat_reg;
    assign CONV_DONE = done;                                             // [RULE10]
    assign INT_MASK  = mask;

endmodule

// >>> test/aim_assertions.sv
`timescale 1ns/100ps
module aim_assertions
    import aim_pkg::*;
(
    input wire logic                    CLK_SYS,
    input wire logic                    RST,
    input wire logic                    WB_CYC_I,
    input wire logic                    WB_STB_I,
    input wire logic                    WB_WE_I,
    input wire logic [AIM_ADR_W-1:0]    WB_ADR_I,
    input wire logic [AIM_SEL_W-1:0]    WB_SEL_I,
    input wire logic [AIM_DAT_W-1:0]    WB_DAT_I,
    input wire logic [AIM_DAT_W-1:0]    WB_DAT_O,
    input wire logic                    WB_ACK_O,
    input wire logic                    IER_WR_STB,
    input wire logic [AIM_SRC_W-1:0]    IER_WR_DATA,
    input wire logic [AIM_EXT_W-1:0]    STATUS_FLAGS,
    input wire logic [AIM_NUM_CH-1:0]   CH_ENABLE,
    input wire logic                    EOC_STB,
    input wire logic [AIM_CH_IDX_W-1:0] EOC_CHAN,
    input wire logic [AIM_NUM_CH-1:0]   CONV_DONE,
    input wire logic [AIM_SRC_W-1:0]    INT_MASK,
    input wire logic                    ADC_IRQ
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // Request taken, and the disable bits it carries
    wire             take     = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire             dis_hit  = take & WB_WE_I & (WB_ADR_I[7:2] == AIM_OFS_INT_DISABLE[7:2]);
    wire [19:0]      dis_bits = WB_DAT_I[19:0];
    ////////////////////////////////////////////////////////////////////////////
    sequence s_dis_wr;
        dis_hit && WB_SEL_I == 4'hF && !IER_WR_STB;
    endsequence
    sequence s_rd_mask;
        take && !WB_WE_I && WB_ADR_I == AIM_OFS_INT_MASK;
    endsequence
    property p_dis_clr;
        s_dis_wr |=> INT_MASK == ($past(INT_MASK) & ~$past(dis_bits));
    endproperty
    a_dis_clr: assert property (p_dis_clr) else $error("disable write wrong");
    property p_ier_set;
        IER_WR_STB |=> (INT_MASK & $past(IER_WR_DATA)) == $past(IER_WR_DATA);
    endproperty
    a_ier_set: assert property (p_ier_set) else $error("enable strobe wrong");
    property p_mask_hold;
        !IER_WR_STB && !dis_hit |=> $stable(INT_MASK);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask moved");
    property p_rd_mask;
        s_rd_mask |=> WB_DAT_O == {12'h000, $past(INT_MASK)};
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("mask read wrong");
    property p_rst_mask;
        $fell(RST) |-> INT_MASK == 20'h00000;
    endproperty
    a_rst_mask: assert property (p_rst_mask) else $error("mask not cleared");
    property p_irq_on;
        STATUS_FLAGS[9] ##1 INT_MASK[AIM_POS_GOVERRUN] |-> ADC_IRQ;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing");
    property p_irq_off;
        INT_MASK == 20'h00000 |-> !ADC_IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq unmasked");
    property p_done_en;
        (CONV_DONE & ~$past(CH_ENABLE)) == 8'h00;
    endproperty
    a_done_en: assert property (p_done_en) else $error("done on idle channel");
    property p_eoc;
        EOC_STB && CH_ENABLE[EOC_CHAN] |=> CONV_DONE[$past(EOC_CHAN)];
    endproperty
    a_eoc: assert property (p_eoc) else $error("done not set");
    property p_ack;
        take |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
endmodule
bind aim_top aim_assertions u_chk (.CLK_SYS, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
    .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .IER_WR_STB, .IER_WR_DATA, .STATUS_FLAGS,
    .CH_ENABLE, .EOC_STB, .EOC_CHAN, .CONV_DONE, .INT_MASK, .ADC_IRQ);

// >>> test/aim_top_tb.sv
`timescale 1ns/100ps
module aim_top_tb
    import aim_pkg::*;
;
    logic        clk, rst, cyc, stb, we, ier, eoc, ack, irq;
    logic [7:0]  adr, chen, done;
    logic [3:0]  sel, lanes;
    logic [31:0] wdat, rdat, q;
    logic [19:0] ierd, mask;
    logic [11:0] flg;
    logic [2:0]  ech;
    logic [9:0]  edat;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc_cnt = 0;
    aim_top u_dut (.CLK_SYS(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .IER_WR_STB(ier), .IER_WR_DATA(ierd), .STATUS_FLAGS(flg), .CH_ENABLE(chen),
        .EOC_STB(eoc), .EOC_CHAN(ech), .EOC_DATA(edat), .CONV_DONE(done), .INT_MASK(mask),
        .ADC_IRQ(irq));
    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard, sized well above the run
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 3000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Classic cycle; held until ack is sampled high at a rising edge, data taken there
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= lanes;
        wdat <= d;
        do
            @(posedge clk);
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        wb(1'b0, a, 32'h0);
        check(nm, q, exp);
    endtask
    // Converter side strobes, one cycle each
    task automatic pulse_ier(input logic [19:0] d);
        @(posedge clk);
        ier <= 1'b1;
        ierd <= d;
        @(posedge clk);
        ier <= 1'b0;
    endtask
    task automatic conv(input logic [2:0] c, input logic [9:0] d);
        @(posedge clk);
        eoc <= 1'b1;
        ech <= c;
        edat <= d;
        @(posedge clk);
        eoc <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {cyc, stb, we, ier, eoc, adr, wdat, ierd, flg, chen, ech, edat} = '0;
        sel = 4'hF;
        lanes = 4'hF;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(AIM_OFS_INT_MASK, 32'h0, "mask_rst");
        pulse_ier(20'hFFFFF);
        rd(AIM_OFS_INT_MASK, 32'h000FFFFF, "mask_all");
        wb(1'b1, AIM_OFS_INT_DISABLE, 32'hFFFA5A5A);
        rd(AIM_OFS_INT_MASK, 32'h0005A5A5, "mask_dis");
        wb(1'b1, AIM_OFS_INT_MASK, 32'h0);
        rd(AIM_OFS_INT_MASK, 32'h0005A5A5, "mask_ro");
        // Global overrun held while its source is masked, then enabled
        @(posedge clk);
        flg <= 12'h200;
        repeat (3) @(negedge clk);
        check("irq_masked", {31'h0, irq}, 32'h0);
        pulse_ier(20'h20000);
        @(negedge clk);
        check("irq_on", {31'h0, irq}, 32'h1);
        @(posedge clk);
        flg <= 12'h000;
        rd(AIM_OFS_EVT_STATUS, 32'h00020000, "status");
        @(negedge clk);
        check("irq_off", {31'h0, irq}, 32'h0);
        // Half the channels enabled: the others must keep their reset result
        @(posedge clk);
        chen <= 8'h0F;
        for (int c = 0; c < 8; c++)
            conv(3'(c), 10'h3F0 + 10'(c));
        @(negedge clk);
        check("done", {24'h0, done}, 32'h0F);
        for (int c = 0; c < 8; c++)
            rd(AIM_OFS_RESULT_BASE + 8'(4 * c), c < 4 ? 32'h3F0 + c : 32'h0, "res");
        conv(3'd1, 10'h155);
        conv(3'd5, 10'h2AA);
        @(negedge clk);
        check("done_rd", {24'h0, done}, 32'h02);
        rd(AIM_OFS_RESULT_BASE + 8'h04, 32'h155, "res_new");
        rd(AIM_OFS_RESULT_BASE + 8'h14, 32'h0, "res_off");
        wb(1'b1, AIM_OFS_RESULT_BASE, 32'hFFFFFFFF);
        rd(AIM_OFS_RESULT_BASE, 32'h3F0, "res_ro");
        conv(3'd2, 10'h0AA);
        @(posedge clk);
        chen <= 8'h00;
        repeat (2) @(negedge clk);
        check("done_off", {24'h0, done}, 32'h0);
        conv(3'd2, 10'h111);
        rd(AIM_OFS_RESULT_BASE + 8'h08, 32'h0AA, "res_kept");
        rd(8'h80, 32'h0, "unmapped");
        // Only lane 0 enabled: bits 7:0 cleared, the rest of the mask kept
        lanes = 4'h1;
        wb(1'b1, AIM_OFS_INT_DISABLE, 32'hFFFFFFFF);
        lanes = 4'hF;
        rd(AIM_OFS_INT_MASK, 32'h0007A500, "mask_lane");
        check("mask_pin", {12'h0, mask}, 32'h0007A500);
        wb(1'b1, AIM_OFS_INT_DISABLE, 32'hFFFFFFFF);
        rd(AIM_OFS_INT_MASK, 32'h0, "mask_none");
        wrap_up();
    end
endmodule
